// ---- rtl/hfcwi_insert.sv ----
// control word inserter: axi4-lite registers, table, frame substitution
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module hfcwi_insert (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cwValid,
    input wire logic [7:0] cwPos,
    input wire logic [2:0] cwSeq,
    input wire logic [31:0] cwIn,
    output logic cwOutValid,
    output logic [31:0] cwOut,
    output logic cwInserted
);
    import hfcwi_pkg::*;

    logic rstSync1, rstSync2;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    wire rst_n = rstSync2;

    // write channel: latch address and data independently, answer after both
    logic awHeld, wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic insertEn;
    hfcwi_index_s idx;
    logic [31:0] loadCount;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire wrConfig = doWrite && awAddr == OFF_CONFIG;
    wire wrIndex = doWrite && awAddr == OFF_INDEX;
    wire wrData = doWrite && awAddr == OFF_DATA;
    wire wrKnown = awAddr == OFF_CONFIG || awAddr == OFF_INDEX
        || awAddr == OFF_DATA || awAddr == OFF_STATUS;
    wire [31:0] idxWord = {15'h0000, idx.insert, 5'h00, idx.seq, idx.x};
    wire [31:0] mergedIdx = {s_axi_wdata_m(wData, wStrb, idxWord)};

    function automatic logic [31:0] s_axi_wdata_m(input logic [31:0] d,
            input logic [3:0] st, input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    wire [31:0] mergedCfg = s_axi_wdata_m(wData, wStrb, {31'h0, insertEn});

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 12'h000;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !awTake;
            s_axi_wready <= !wHeld && !wTake;
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
        end
    end

    // control registers; insert bit of the index register lands in the table
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            insertEn <= CONFIG_RESET[CFG_INSERT_EN_BIT];
            idx <= '0;
            loadCount <= 32'h0000_0000;
        end else begin
            if (wrConfig) begin
                insertEn <= mergedCfg[CFG_INSERT_EN_BIT];
            end
            if (wrIndex) begin
                idx.x <= mergedIdx[IDX_X_LSB +: 8];
                idx.seq <= mergedIdx[IDX_SEQ_LSB +: 3];
                idx.insert <= mergedIdx[IDX_INSERT_BIT];
            end
            if (wrData) begin
                loadCount <= loadCount + 32'h0000_0001;
            end
        end
    end

    hfcwi_wr_s tblWr;
    // full words only; a partial strobe on the data register still stores
    // the whole word, since sections carry no byte meaning of their own
    assign tblWr = '{valid: wrData && idx.seq < 3'(HFCWI_SECTIONS), x: idx.x,
                     seq: idx.seq, data: wData};

    hfcwi_slot_s slot;
    assign slot = '{pos: cwPos, seq: cwSeq};
    logic [31:0] slotData;
    logic slotEnable;

    hfcwi_table #(
        .ENTRIES(HFCWI_ENTRIES),
        .SECTIONS(HFCWI_SECTIONS)
    ) u_table (
        .mclk(mclk),
        .rst_n(rst_n),
        .wrReq(tblWr),
        .enWrite(wrIndex),
        .enIndex(mergedIdx[IDX_X_LSB +: 8]),
        .enValue(mergedIdx[IDX_INSERT_BIT]),
        .slot(slot),
        .slotData(slotData),
        .slotEnable(slotEnable)
    );

    // read channel
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire [11:0] rdAddr = {s_axi_araddr[11:2], 2'b00};
    wire rdKnown = rdAddr == OFF_CONFIG || rdAddr == OFF_INDEX
        || rdAddr == OFF_DATA || rdAddr == OFF_STATUS;
    wire [31:0] rdMux = rdAddr == OFF_CONFIG ? {31'h0, insertEn}
        : rdAddr == OFF_INDEX ? idxWord
        : rdAddr == OFF_STATUS ? loadCount : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !arTake;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdKnown ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // frame path: one registered stage, substitution on enable and master
    wire doInsert = cwValid && insertEn && slotEnable
        && cwSeq < 3'(HFCWI_SECTIONS);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cwOutValid <= 1'b0;
            cwOut <= 32'h0000_0000;
            cwInserted <= 1'b0;
        end else begin
            cwOutValid <= cwValid;
            cwOut <= doInsert ? slotData : cwIn;
            cwInserted <= doInsert;
        end
    end

    a_no_insert_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !insertEn |=> !cwInserted)
        else $error("insertion while master enable clear");
    a_insert_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        cwInserted |-> $past(cwValid) && $past(slotEnable) && $past(insertEn))
        else $error("insertion without cause");
    a_pass_through: assert property (@(posedge mclk) disable iff (!rst_n)
        cwValid && !doInsert |=> cwOut == $past(cwIn))
        else $error("pass-through word altered");
    a_insert_data: assert property (@(posedge mclk) disable iff (!rst_n)
        doInsert |=> cwOut == $past(slotData))
        else $error("inserted word not table data");
    sequence s_load;
        wrData && idx.seq < 3'(HFCWI_SECTIONS);
    endsequence
    a_load_count: assert property (@(posedge mclk) disable iff (!rst_n)
        s_load |=> loadCount == $past(loadCount) + 32'h0000_0001)
        else $error("data write not counted");
    a_bresp_once: assert property (@(posedge mclk) disable iff (!rst_n)
        doWrite |=> s_axi_bvalid ##1 !doWrite)
        else $error("write answered twice");
    a_en_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !wrConfig |=> insertEn == $past(insertEn))
        else $error("master enable changed without write");
    a_idx_insert: assert property (@(posedge mclk) disable iff (!rst_n)
        wrIndex |=> idx.insert == $past(mergedIdx[IDX_INSERT_BIT]))
        else $error("insert bit not stored");
endmodule // hfcwi_insert

// ---- rtl/hfcwi_pkg.sv ----
// package: register map, field layout and sizes for the control word inserter
package hfcwi_pkg;
    localparam int HFCWI_ENTRIES = 256;
    localparam int HFCWI_SECTIONS = 5;
    localparam logic [11:0] OFF_CONFIG = 12'h000;
    localparam logic [11:0] OFF_INDEX = 12'h004;
    localparam logic [11:0] OFF_DATA = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam int CFG_INSERT_EN_BIT = 0;
    localparam int IDX_X_LSB = 0;
    localparam int IDX_SEQ_LSB = 8;
    localparam int IDX_INSERT_BIT = 16;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] INDEX_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] x;
        logic [2:0] seq;
        logic insert;
    } hfcwi_index_s;

    typedef struct packed {
        logic valid;
        logic [7:0] x;
        logic [2:0] seq;
        logic [31:0] data;
    } hfcwi_wr_s;

    typedef struct packed {
        logic [7:0] pos;
        logic [2:0] seq;
    } hfcwi_slot_s;
endpackage

// ---- rtl/hfcwi_table.sv ----
// table storage: 256 entries of five sections plus a per-entry enable
`timescale 1ns/1ns
module hfcwi_table #(
    parameter int ENTRIES = 256,
    parameter int SECTIONS = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire hfcwi_pkg::hfcwi_wr_s wrReq,
    input wire logic enWrite,
    input wire logic [7:0] enIndex,
    input wire logic enValue,
    input wire hfcwi_pkg::hfcwi_slot_s slot,
    output logic [31:0] slotData,
    output logic slotEnable
);
    import hfcwi_pkg::*;

    logic [31:0] sect [SECTIONS][ENTRIES];
    logic [ENTRIES-1:0] entryEn;

    // each section is its own bank so a write never disturbs the others
    genvar s;
    generate
        for (s = 0; s < SECTIONS; s++) begin : g_bank
            always_ff @(posedge mclk) begin
                if (wrReq.valid && wrReq.seq == 3'(s)) begin
                    sect[s][wrReq.x] <= wrReq.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            entryEn <= '0;
        end else if (enWrite) begin
            entryEn[enIndex] <= enValue;
        end
    end

    wire [2:0] rdSeq = (slot.seq < 3'(SECTIONS)) ? slot.seq : 3'd0;
    assign slotData = sect[rdSeq][slot.pos];
    assign slotEnable = entryEn[slot.pos];
endmodule // hfcwi_table

// ---- tb/tb_top.sv ----
// self-checking testbench for the control word inserter
`timescale 1ns/1ns
module tb_top;
    import hfcwi_pkg::*;
    logic mclk = 1'h0, arst_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cwValid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, cwIn = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] cwPos = 8'h00;
    logic [2:0] cwSeq = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, cwOut, curIdx;
    logic cwOutValid, cwInserted, glob;
    logic [31:0] tbl [HFCWI_ENTRIES][HFCWI_SECTIONS];
    logic en [HFCWI_ENTRIES];
    logic [7:0] vx [6] = '{8'h10, 8'h50, 8'h90, 8'hD0, 8'h00, 8'hFF};
    int fails, samplesChecked, cycles, nData;
    always #4 mclk = ~mclk;
    hfcwi_insert u_dut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cwValid, .cwPos,
        .cwSeq, .cwIn, .cwOutValid, .cwOut, .cwInserted);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] idxw(input logic [7:0] x, input int s, input bit ins);
        return {15'h0000, ins, 5'h00, 3'(s), x};
    endfunction
    // master offers address and data together; the bench model follows each write
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit b;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 0;
        while (!b) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                b = 1;
                r = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'h0;
        if (a == OFF_CONFIG && s_axi_wstrb[0]) glob = d[CFG_INSERT_EN_BIT];
        if (a == OFF_INDEX) begin
            curIdx = d;
            en[d[7:0]] = d[IDX_INSERT_BIT];
        end
        // status counts every data write, ignored sections too
        if (a == OFF_DATA) nData++;
        if (a == OFF_DATA && curIdx[IDX_SEQ_LSB+:3] < 3'h5) begin
            tbl[curIdx[7:0]][curIdx[IDX_SEQ_LSB+:3]] = d;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        bit got;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        got = 0;
        while (!got) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                got = 1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'h0;
    endtask
    // back-to-back words; each answer is sampled two edges after it was driven
    task automatic burst(input int n);
        logic [7:0] p [$];
        logic [2:0] s [$];
        logic [31:0] c [$];
        logic [7:0] hp;
        logic [2:0] hs;
        logic [31:0] hc;
        bit e;
        for (int k = 0; k < n + 2; k++) begin
            @(posedge mclk);
            if (k >= 2) begin
                hp = p.pop_front();
                hs = s.pop_front();
                hc = c.pop_front();
                e = glob && en[hp];
                check("cwOutValid", {31'h0000_0000, cwOutValid}, 32'h0000_0001);
                check("cwInserted", {31'h0000_0000, cwInserted}, {31'h0000_0000, e});
                check("cwOut", cwOut, e ? tbl[hp][hs] : hc);
            end
            if (k < n) begin
                p.push_back(($urandom % 4 != 0) ? vx[$urandom % 6] : 8'($urandom));
                s.push_back(3'($urandom % 5));
                c.push_back($urandom);
                cwPos <= p[$];
                cwSeq <= s[$];
                cwIn <= c[$];
            end
            cwValid <= (k < n);
        end
        @(posedge mclk);
        check("cwOutValid idle", {31'h0000_0000, cwOutValid}, 32'h0000_0000);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(42));
        glob = 0;
        foreach (en[i]) en[i] = 0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'h1;
        repeat (4) @(posedge mclk);
        rd(OFF_CONFIG, d, r);
        check("config reset", d, CONFIG_RESET);
        check("config rresp", {30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY});
        rd(OFF_INDEX, d, r);
        check("index reset", d, INDEX_RESET);
        rd(12'h0FC, d, r);
        check("unmapped rresp", {30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
        check("unmapped rdata", d, 32'h0000_0000);
        wr(12'h0F0, $urandom, r);
        check("unmapped bresp", {30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
        $display("test registers done");
        // vendor words plus both ends of the table; section five must be ignored
        foreach (vx[i]) begin
            for (int s = 0; s <= HFCWI_SECTIONS; s++) begin
                wr(OFF_INDEX, idxw(vx[i], s, 0), r);
                wr(OFF_DATA, $urandom, r);
            end
            wr(OFF_INDEX, idxw(vx[i], 0, 1), r);
        end
        rd(OFF_INDEX, d, r);
        check("index readback", d, curIdx);
        rd(OFF_DATA, d, r);
        check("data reads zero", d, 32'h0000_0000);
        rd(OFF_STATUS, d, r);
        check("status count", d, 32'(nData));
        burst(40);
        $display("test master off done");
        wr(OFF_CONFIG, 32'h0000_0001, r);
        check("config bresp", {30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY});
        burst(200);
        burst(200);
        $display("test insertion done");
        wr(OFF_INDEX, idxw(vx[1], 0, 0), r);
        burst(100);
        wr(OFF_CONFIG, 32'h0000_0000, r);
        burst(30);
        // strobe without lane zero must leave the master enable alone
        s_axi_wstrb <= 4'hE;
        wr(OFF_CONFIG, 32'h0000_0001, r);
        s_axi_wstrb <= 4'hF;
        rd(OFF_CONFIG, d, r);
        check("config strobe", d, {31'h0000_0000, glob});
        burst(20);
        $display("test enables done");
        end_of_test();
    end
endmodule // tb_top
